/* File: logic/encoder_pulse_divider_output.sv */
// divides the motor encoder pulse train into a/b/c differential outputs
`timescale 1ns/100ps
`default_nettype none
module encoder_pulse_divider_output #(
  parameter int DIV_W = 16,
  parameter int ACC_W = 17
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // motor encoder pins
  input wire logic motor_encoder_a,
  input wire logic motor_encoder_b,
  input wire logic motor_encoder_z,
  // configuration, sampled once after reset
  input wire logic [DIV_W-1:0] pulse_divider_setting,
  input wire logic [1:0] encoder_resolution,
  // speed, torque or position control running
  input wire logic control_active,
  // differential divided outputs
  output logic div_out_a,
  output logic div_out_a_n,
  output logic div_out_b,
  output logic div_out_b_n,
  output logic div_out_marker,
  output logic div_out_marker_n
);

  if (DIV_W < 16 || ACC_W < DIV_W + 1)
  begin : g_bad_width
    $error("divider or accumulator width too small");
  end

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    enc_div_pkg::run_t run;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] ppr;
    logic [ACC_W-1:0] acc;
    logic [1:0] phase;
    logic a;
    logic a_n;
    logic b;
    logic b_n;
    logic m;
    logic m_n;
  } state_t;

  state_t s_q;
  state_t s_d;

  quad_if ev ();

  logic [ACC_W-1:0] sum;
  logic [DIV_W-1:0] ppr_sel;
  logic [DIV_W-1:0] div_sel;

  quad_decode u_decode (
    .clk(clk),
    .reset(reset),
    .enc_a(s_q.sync2[0]),
    .enc_b(s_q.sync2[1]),
    .ev(ev.src)
  );

  // encoder resolution picks pulses per revolution and the setting limit
  always_comb
  begin
    unique case (enc_div_pkg::res_t'(encoder_resolution))
      enc_div_pkg::RES_13: ppr_sel = DIV_W'(enc_div_pkg::PPR_13BIT);
      enc_div_pkg::RES_16: ppr_sel = DIV_W'(enc_div_pkg::PPR_16BIT);
      enc_div_pkg::RES_17: ppr_sel = DIV_W'(enc_div_pkg::PPR_17BIT);
      default: ppr_sel = DIV_W'(enc_div_pkg::PPR_17BIT);
    endcase
  end

  // clamp the setting into the range the encoder can serve
  always_comb
  begin
    if (pulse_divider_setting < DIV_W'(enc_div_pkg::DIV_MIN))
    begin
      div_sel = DIV_W'(enc_div_pkg::DIV_MIN);
    end
    else if (pulse_divider_setting > DIV_W'(enc_div_pkg::DIV_MAX))
    begin
      div_sel = DIV_W'(enc_div_pkg::DIV_MAX);
    end
    else
    begin
      div_sel = pulse_divider_setting;
    end
    if (div_sel > ppr_sel && ppr_sel < DIV_W'(enc_div_pkg::DIV_MAX))
    begin
      div_sel = ppr_sel;
    end
  end

  assign sum = s_q.acc + ACC_W'(s_q.div);

  always_comb
  begin
    s_d = s_q;
    s_d.sync1 = {motor_encoder_z, motor_encoder_b, motor_encoder_a};
    s_d.sync2 = s_q.sync1;
    unique case (s_q.run)
      enc_div_pkg::ST_LOAD:
      begin
        // setting is frozen here until the next reset
        s_d.div = div_sel;
        s_d.ppr = ppr_sel;
        s_d.acc = '0;
        s_d.run = enc_div_pkg::ST_RUN;
      end
      enc_div_pkg::ST_RUN:
      begin
        if (control_active && ev.step)
        begin
          // rate scaling: one output edge per ppr/div encoder edges
          if (ev.dir)
          begin
            if (sum >= ACC_W'(s_q.ppr))
            begin
              s_d.acc = sum - ACC_W'(s_q.ppr);
              s_d.phase = s_q.phase + 2'h1;
            end
            else
            begin
              s_d.acc = sum;
            end
          end
          else
          begin
            if (s_q.acc >= ACC_W'(s_q.div))
            begin
              s_d.acc = s_q.acc - ACC_W'(s_q.div);
            end
            else
            begin
              s_d.acc = s_q.acc + ACC_W'(s_q.ppr) - ACC_W'(s_q.div);
              s_d.phase = s_q.phase - 2'h1;
            end
          end
        end
      end
    endcase
    // gray phase: forward steps make a lead b by 90 degrees
    s_d.a = s_d.phase[1] ^ s_d.phase[0];
    s_d.b = s_d.phase[1];
    s_d.a_n = ~s_d.a;
    s_d.b_n = ~s_d.b;
    // marker follows the encoder index only while control_active is high, untouched by the divider
    s_d.m = control_active & s_q.sync2[2];
    s_d.m_n = ~s_d.m;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q.sync1 <= '0;
      s_q.sync2 <= '0;
      s_q.run <= enc_div_pkg::ST_LOAD;
      s_q.div <= DIV_W'(enc_div_pkg::DIV_RESET);
      s_q.ppr <= DIV_W'(enc_div_pkg::PPR_17BIT);
      s_q.acc <= '0;
      s_q.phase <= enc_div_pkg::PHASE_RESET;
      s_q.a <= 1'b0;
      s_q.a_n <= 1'b1;
      s_q.b <= 1'b0;
      s_q.b_n <= 1'b1;
      s_q.m <= 1'b0;
      s_q.m_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // the gear ratio lives elsewhere and never reaches this path
  assign div_out_a = s_q.a;
  assign div_out_a_n = s_q.a_n;
  assign div_out_b = s_q.b;
  assign div_out_b_n = s_q.b_n;
  assign div_out_marker = s_q.m;
  assign div_out_marker_n = s_q.m_n;

endmodule // encoder_pulse_divider_output
`default_nettype wire

/* File: include/enc_div_pkg.sv */
// constants and types for the encoder pulse divider output
package enc_div_pkg;

  // encoder pulses per revolution for each resolution
  localparam logic [15:0] PPR_13BIT = 16'h0800;
  localparam logic [15:0] PPR_16BIT = 16'h4000;
  localparam logic [15:0] PPR_17BIT = 16'h8000;

  // divider setting limits and reset value
  localparam logic [15:0] DIV_MIN = 16'h0010;
  localparam logic [15:0] DIV_MAX = 16'h4000;
  localparam logic [15:0] DIV_RESET = 16'h4000;

  // output phase counter reset value
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // encoder resolution strap
  typedef enum logic [1:0] {RES_13, RES_16, RES_17} res_t;

  // power-up capture sequence
  typedef enum logic [0:0] {ST_LOAD, ST_RUN} run_t;

endpackage

/* File: include/quad_if.sv */
// step and direction events from the quadrature decoder
`timescale 1ns/100ps
`default_nettype none
interface quad_if;
  logic step;
  logic dir;
  modport src (output step, output dir);
  modport snk (input step, input dir);
endinterface
`default_nettype wire

/* File: logic/quad_decode.sv */
// quadrature decoder turning synchronised a/b levels into count events
`timescale 1ns/100ps
`default_nettype none
module quad_decode (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // synchronised encoder phases
  input wire logic enc_a,
  input wire logic enc_b,
  // count events
  quad_if.src ev
);

  typedef struct packed {
    logic a;
    logic b;
    logic step;
    logic dir;
    logic [1:0] warm;
  } dec_t;

  dec_t s_q;
  dec_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.a = enc_a;
    s_d.b = enc_b;
    s_d.step = 1'b0;
    s_d.dir = 1'b0;
    // forward when a leads b: 00 -> 10 -> 11 -> 01 -> 00
    unique case ({s_q.a, s_q.b, enc_a, enc_b})
      4'h2, 4'hb, 4'hd, 4'h4:
      begin
        s_d.step = 1'b1;
        s_d.dir = 1'b1;
      end
      4'h1, 4'h7, 4'he, 4'h8:
      begin
        s_d.step = 1'b1;
        s_d.dir = 1'b0;
      end
      // no change, or a double jump that cannot be resolved
      default:
      begin
        s_d.step = 1'b0;
      end
    endcase
    // the first compares after reset see the cleared synchroniser, not the pin
    s_d.warm = (s_q.warm == 2'h3) ? s_q.warm : s_q.warm + 2'h1;
    if (s_q.warm != 2'h3)
    begin
      s_d.step = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ev.step = s_q.step;
  assign ev.dir = s_q.dir;

endmodule // quad_decode
`default_nettype wire

/* File: tb/enc_div_properties.sv */
// checker for the divided encoder outputs
`timescale 1ns/100ps
`default_nettype none
module enc_div_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // encoder and control
  input wire logic motor_encoder_a,
  input wire logic motor_encoder_b,
  input wire logic motor_encoder_z,
  input wire logic control_active,
  // outputs
  input wire logic div_out_a,
  input wire logic div_out_a_n,
  input wire logic div_out_b,
  input wire logic div_out_b_n,
  input wire logic div_out_marker,
  input wire logic div_out_marker_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  AST_A_PAIR: assert property (div_out_a_n == !div_out_a)
    else $error("phase a pair not complementary");
  AST_B_PAIR: assert property (div_out_b_n == !div_out_b)
    else $error("phase b pair not complementary");
  AST_C_PAIR: assert property (div_out_marker_n == !div_out_marker)
    else $error("marker pair not complementary");
  AST_QUAD: assert property (!($changed(div_out_a) && $changed(div_out_b)))
    else $error("a and b changed together");
  AST_FREEZE: assert property (!control_active [*4] |-> $stable({div_out_a, div_out_b}))
    else $error("outputs moved while control inactive");
  AST_MARK_OFF: assert property (!control_active [*4] |-> !div_out_marker)
    else $error("marker while control inactive");
  AST_MARK_FOLLOW: assert property ((control_active && !reset) [*4]
    |-> div_out_marker == $past(motor_encoder_z, 3))
    else $error("marker does not follow index");
  AST_NO_RAW: assert property ($stable({motor_encoder_a, motor_encoder_b}) [*6]
    |-> $stable({div_out_a, div_out_b}))
    else $error("output step without encoder motion");
endmodule // enc_div_properties
`default_nettype wire

/* File: tb/host_rx.sv */
// host receiver model counting output edges and marker pulses
`timescale 1ns/100ps
`default_nettype none
module host_rx (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // received phases
  input wire logic a,
  input wire logic b,
  input wire logic mk,
  // counts, four-state so an unknown output shows up
  output integer edges,
  output integer marks,
  output integer net
);
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  logic mk_q = 1'b0;
  initial edges = 0;
  initial marks = 0;
  initial net = 0;
  // one edge of a or b is a quarter output pulse; counting holds while reset
  always @(posedge clk)
  begin
    if (!reset)
    begin
      edges <= edges + integer'(a ^ a_q) + integer'(b ^ b_q);
      marks <= marks + integer'(mk & !mk_q);
      // a leading b counts up, b leading a counts down
      case ({a_q, b_q, a, b})
        4'h2, 4'hb, 4'hd, 4'h4: net <= net + 1;
        4'h1, 4'h7, 4'he, 4'h8: net <= net - 1;
        default: net <= net;
      endcase
    end
    a_q <= a;
    b_q <= b;
    mk_q <= mk;
  end
endmodule // host_rx
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench for the encoder pulse divider output
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ea = 1'b0;
  logic eb = 1'b0;
  logic ez = 1'b0;
  logic ca = 1'b1;
  logic [15:0] setting = 16'h0010;
  logic [1:0] res = 2'h0;
  logic [1:0] pos = 2'h0;
  logic oa, oan, ob, obn, om, omn;
  integer edges, marks, net;
  int fails = 0;
  int checked = 0;
  always #25 clk = ~clk;
  encoder_pulse_divider_output DUT (.clk(clk), .reset(reset), .motor_encoder_a(ea),
    .motor_encoder_b(eb), .motor_encoder_z(ez), .pulse_divider_setting(setting),
    .encoder_resolution(res), .control_active(ca), .div_out_a(oa), .div_out_a_n(oan),
    .div_out_b(ob), .div_out_b_n(obn), .div_out_marker(om), .div_out_marker_n(omn));
  host_rx rx (.clk(clk), .reset(reset), .a(oa), .b(ob), .mk(om), .edges(edges),
    .marks(marks), .net(net));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input integer got, input int exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic restart(input logic [15:0] s, input logic [1:0] r);
    reset = 1'b1;
    setting = s;
    res = r;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // n encoder counts, index high at count zat of each 13-bit turn; a leads b going forward
  task automatic move(input int n, input logic fwd, input int zat, output integer de,
    output integer dm);
    integer e0;
    integer m0;
    e0 = edges;
    m0 = marks;
    for (int i = 0; i < n; i++)
    begin
      pos = fwd ? pos + 2'h1 : pos - 2'h1;
      ea = pos[1] ^ pos[0];
      eb = pos[1];
      ez = (i % 8192 == zat);
      repeat (3) @(negedge clk);
    end
    ez = 1'b0;
    repeat (8) @(negedge clk);
    de = edges - e0;
    dm = marks - m0;
  endtask
  // two turns of a 13-bit encoder at divider 16; the host sees one marker pulse per turn
  task automatic test_ratio();
    integer de, dm, n0;
    restart(16'h0010, 2'h0);
    n0 = net;
    move(16384, 1'b1, 4096, de, dm);
    check(de, 128);
    check(dm, 2);
    check(net - n0, 128);
  endtask
  task automatic test_clamp_hold();
    integer de, dm;
    restart(16'h4000, 2'h0);
    move(100, 1'b1, -1, de, dm);
    check(de, 100);
    setting = 16'h0010;
    move(100, 1'b1, -1, de, dm);
    check(de, 100);
    restart(16'h0010, 2'h0);
    move(512, 1'b1, -1, de, dm);
    check(de, 4);
    restart(16'h4000, 2'h2);
    move(100, 1'b1, -1, de, dm);
    check(de, 50);
    restart(16'hffff, 2'h1);
    move(100, 1'b1, -1, de, dm);
    check(de, 100);
    restart(16'h0001, 2'h0);
    move(512, 1'b1, -1, de, dm);
    check(de, 4);
  endtask
  task automatic test_inactive();
    integer de, dm, n0;
    restart(16'h4000, 2'h0);
    ca = 1'b0;
    move(50, 1'b1, 10, de, dm);
    check(de, 0);
    check(dm, 0);
    ca = 1'b1;
    n0 = net;
    move(60, 1'b0, 20, de, dm);
    check(de, 60);
    check(net - n0, -60);
    check(dm, 1);
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    test_ratio();
    test_clamp_hold();
    test_inactive();
    give_verdict();
  end
  initial
  begin
    #3500000;
    fails++;
    give_verdict();
  end
endmodule // tb_top
bind encoder_pulse_divider_output enc_div_properties chk (.clk(clk), .reset(reset),
  .motor_encoder_a(motor_encoder_a), .motor_encoder_b(motor_encoder_b),
  .motor_encoder_z(motor_encoder_z), .control_active(control_active),
  .div_out_a(div_out_a), .div_out_a_n(div_out_a_n), .div_out_b(div_out_b),
  .div_out_b_n(div_out_b_n), .div_out_marker(div_out_marker),
  .div_out_marker_n(div_out_marker_n));
`default_nettype wire
